// ---- test/gpc_osc_model.sv ----
// free-running oscillator sources seen by the pin clock router
`timescale 1ns/10ps
`default_nettype none

module gpc_osc_model #(
    parameter logic [47:0] HALF = 48'h3c32_2a22_1a14
) (
    output var logic [5:0] osc
);
    // half-ns starts keep every source edge away from the mclk edges
    for (genvar i = 0; i < 6; i++) begin : g_osc
        initial begin
            osc[i] = 1'b0;
            #(i + 0.5);
            forever #(HALF[i*8 +: 8]) osc[i] = ~osc[i];
        end
    end
endmodule

`default_nettype wire

// ---- test/gpc_pad_config_tb.sv ----
// self-checking bench for the pad configuration block
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs.svh"

module gpc_pad_config_tb
    import gpc_pkg::*;
;
    // oscillator half periods in ns, source 0 in the low byte
    localparam logic [47:0] HALF = 48'h3c32_2a22_1a14;

    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic [31:0] reg_addr = 32'h0000_0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        func_out_data = 1'b0;
    logic [15:0] reg_rdata;
    logic [5:0]  osc;
    logic [5:0]  pin_function_sel;
    logic        drive_type_sel;
    logic [1:0]  direction_pull_sel;
    logic [2:0]  pin_clock_source_sel;
    logic        pad_o;
    logic        pad_oe;
    logic        pad_input_en;
    logic        pad_pull_up_en;
    logic        pad_pull_down_en;
    logic        pad_analog_en;
    logic [1:0]  port0_rail_sel;
    logic [7:0]  port1_rail_sel;
    logic [4:0]  port2_rail_sel;
    logic [7:0]  port3_rail_sel;
    logic [7:0]  port4_rail_sel;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    logic [15:0] rnd = 16'ha895;
    logic [15:0] sh [7];
    logic [31:0] ad [7] = '{`GPC_MODE_OFS, `GPC_SUP0_OFS, `GPC_SUP1_OFS, `GPC_SUP2_OFS,
                            `GPC_SUP3_OFS, `GPC_SUP4_OFS, `GPC_CSEL_OFS};
    logic [15:0] mk [7] = '{`GPC_MODE_MASK, `GPC_SUP0_MASK, `GPC_SUP8_MASK, `GPC_SUP2_MASK,
                            `GPC_SUP8_MASK, `GPC_SUP8_MASK, `GPC_CSEL_MASK};

    always #2 mclk = ~mclk;

    gpc_osc_model #(.HALF(HALF)) osc_u (.osc(osc));

    gpc_pad_config dut_u (
        .mclk                  (mclk),
        .arst_n                (arst_n),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_wr                (reg_wr),
        .reg_rd                (reg_rd),
        .reg_rdata             (reg_rdata),
        .func_out_data         (func_out_data),
        .low_freq_crystal_osc  (osc[0]),
        .low_freq_rc_osc       (osc[1]),
        .trimmed_rc_osc        (osc[2]),
        .high_freq_crystal_osc (osc[3]),
        .high_freq_rc_osc      (osc[4]),
        .divided_system_clock  (osc[5]),
        .pin_function_sel      (pin_function_sel),
        .drive_type_sel        (drive_type_sel),
        .direction_pull_sel    (direction_pull_sel),
        .pin_clock_source_sel  (pin_clock_source_sel),
        .pad_o                 (pad_o),
        .pad_oe                (pad_oe),
        .pad_input_en          (pad_input_en),
        .pad_pull_up_en        (pad_pull_up_en),
        .pad_pull_down_en      (pad_pull_down_en),
        .pad_analog_en         (pad_analog_en),
        .port0_rail_sel        (port0_rail_sel),
        .port1_rail_sel        (port1_rail_sel),
        .port2_rail_sel        (port2_rail_sel),
        .port3_rail_sel        (port3_rail_sel),
        .port4_rail_sel        (port4_rail_sel)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
    endfunction

    // expected {oe, o, input_en, pull_up, pull_down, analog}
    function automatic logic [5:0] pad_exp(input logic [15:0] m, input logic d);
        if (m[5:0] == `GPC_FUNC_ADC) return 6'h01;
        case (m[9:8])
            2'h0: return 6'h08;
            2'h1: return 6'h0c;
            2'h2: return 6'h0a;
            default: return m[10] ? {~d, 5'h00} : {1'b1, d, 4'h0};
        endcase
    endfunction

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
        @(posedge mclk);
        #1;
        check(reg_rdata, 16'h0000);
    endtask

    // read strobe follows the write strobe at the very next edge
    task automatic wr_rd(input logic [31:0] a, input logic [15:0] d, input logic [15:0] e);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic chk_outs();
        logic [5:0] pads;
        check(16'(pin_function_sel), 16'(sh[0][5:0]));
        check(16'(drive_type_sel), 16'(sh[0][10]));
        check(16'(direction_pull_sel), 16'(sh[0][9:8]));
        check(16'(port0_rail_sel), 16'(sh[1][7:6]));
        check(16'(port1_rail_sel), 16'(sh[2][7:0]));
        check(16'(port2_rail_sel), 16'(sh[3][4:0]));
        check(16'(port3_rail_sel), 16'(sh[4][7:0]));
        check(16'(port4_rail_sel), 16'(sh[5][7:0]));
        check(16'(pin_clock_source_sel), 16'(sh[6][2:0]));
        pads = {pad_oe, pad_o, pad_input_en, pad_pull_up_en, pad_pull_down_en, pad_analog_en};
        // the routed clock is free-running, so its pad value is counted instead
        if (sh[0][5:0] != `GPC_CLOCK_OUTPUT_FUNCTION_OUT) begin
            check(16'(pads), 16'(pad_exp(sh[0], func_out_data)));
        end
    endtask

    task automatic do_reset(input int n);
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (n) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        sh = '{`GPC_MODE_RST, `GPC_SUP_RST, `GPC_SUP_RST, `GPC_SUP_RST, `GPC_SUP_RST,
               `GPC_SUP_RST, `GPC_CSEL_RST};
        chk_outs();
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        logic [15:0] v;
        logic        last;
        int          i;
        int          k;
        int          e;
        int          tol;
        int          edges;
        do_reset(20);
        for (i = 0; i < 7; i++) rd_chk(ad[i], sh[i]);
        rd_chk(32'h5000_30ca, 16'h0000);
        // random traffic, every eighth write to an unmapped hole
        for (k = 0; k < 60; k++) begin
            rnd = lfsr(rnd);
            i = int'(rnd[2:0]) % 7;
            rnd = lfsr(rnd);
            @(posedge mclk);
            func_out_data <= rnd[15];
            if (k % 8 == 7) begin
                wr(32'h5000_30ce, rnd);
            end else begin
                wr(ad[i], rnd);
                sh[i] = rnd & mk[i];
            end
            settle();
            chk_outs();
            rd_chk(ad[i], sh[i]);
        end
        // write then read with no idle edge between the strobes
        for (k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            sh[0] = rnd & mk[0];
            wr_rd(ad[0], rnd, sh[0]);
        end
        // every direction code, both drive types and data levels, plain and converter
        for (k = 0; k < 32; k++) begin
            v = {5'h00, k[0], k[2:1], 2'h0, (k[4] ? `GPC_FUNC_ADC : 6'h00)};
            @(posedge mclk);
            func_out_data <= k[3];
            wr(ad[0], v);
            sh[0] = v;
            settle();
            chk_outs();
        end
        wr(ad[0], 16'h0330);
        sh[0] = 16'h0330;
        for (k = 0; k < 8; k++) begin
            wr(ad[6], 16'(k));
            sh[6] = 16'(k);
            repeat (8) @(posedge mclk);
            #1;
            chk_outs();
            check(16'(pad_oe), 16'h0001);
            e = (k < 6) ? 2000 / int'(HALF[k*8 +: 8]) : 0;
            tol = (k < 6) ? 2 : 0;
            edges = 0;
            last = pad_o;
            repeat (1000) begin
                @(posedge mclk);
                #1;
                if (pad_o && !last) edges++;
                last = pad_o;
            end
            check(16'(edges >= e - tol && edges <= e + tol), 16'h0001);
        end
        // reset in mid-run must restore every field
        do_reset(3);
        close_out();
    end
endmodule

`default_nettype wire

// ---- verilog/gpc_clk_route.sv ----
// synchronises the oscillator clocks and picks the one routed to the pin
`timescale 1ns/10ps
`default_nettype none

module gpc_clk_route
    import gpc_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         low_freq_crystal_osc,
    input  wire logic         low_freq_rc_osc,
    input  wire logic         trimmed_rc_osc,
    input  wire logic         high_freq_crystal_osc,
    input  wire logic         high_freq_rc_osc,
    input  wire logic         divided_system_clock,
    input  wire gpc_clk_src_t sel,
    output logic              clk_out
);

    logic [5:0] meta_q;
    logic [5:0] sync_q;
    logic       out_q;
    logic       out_d;

    // sampling at mclk limits the routed clock to well below half of mclk
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
            out_q  <= 1'b0;
        end else begin
            meta_q <= {divided_system_clock, high_freq_rc_osc, high_freq_crystal_osc,
                       trimmed_rc_osc, low_freq_rc_osc, low_freq_crystal_osc};
            sync_q <= meta_q;
            out_q  <= out_d;
        end
    end

    always_comb begin
        unique case (sel)
            src_low_freq_crystal:  out_d = sync_q[0];
            src_low_freq_rc:       out_d = sync_q[1];
            src_trimmed_rc:        out_d = sync_q[2];
            src_high_freq_crystal: out_d = sync_q[3];
            src_high_freq_rc:      out_d = sync_q[4];
            src_divided_sys:       out_d = sync_q[5];
            src_reserved6:         out_d = 1'b0;
            src_reserved7:         out_d = 1'b0;
        endcase
    end

    assign clk_out = out_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    reserved_quiet_a: assert property (
        (sel == src_reserved6 || sel == src_reserved7) |=> !clk_out)
        else $error("reserved clock select drove the pin clock");

endmodule

`default_nettype wire

// ---- verilog/gpc_pad_config.sv ----
// pad configuration registers and pad control for one general purpose pin
`timescale 1ns/10ps
`default_nettype none
`include "gpc_regs.svh"

module gpc_pad_config
    import gpc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic [31:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        func_out_data,
    input  wire logic        low_freq_crystal_osc,
    input  wire logic        low_freq_rc_osc,
    input  wire logic        trimmed_rc_osc,
    input  wire logic        high_freq_crystal_osc,
    input  wire logic        high_freq_rc_osc,
    input  wire logic        divided_system_clock,
    output logic       [5:0] pin_function_sel,
    output logic             drive_type_sel,
    output logic       [1:0] direction_pull_sel,
    output logic       [2:0] pin_clock_source_sel,
    output logic             pad_o,
    output logic             pad_oe,
    output logic             pad_input_en,
    output logic             pad_pull_up_en,
    output logic             pad_pull_down_en,
    output logic             pad_analog_en,
    output logic       [1:0] port0_rail_sel,
    output logic       [7:0] port1_rail_sel,
    output logic       [4:0] port2_rail_sel,
    output logic       [7:0] port3_rail_sel,
    output logic       [7:0] port4_rail_sel
);

    // address decode shared by the write and read paths
    function automatic gpc_reg_t reg_decode(input logic [31:0] addr);
        gpc_reg_t r;
        r = sel_none;
        unique case (addr)
            `GPC_MODE_OFS: r = sel_mode;
            `GPC_SUP0_OFS: r = sel_sup0;
            `GPC_SUP1_OFS: r = sel_sup1;
            `GPC_SUP2_OFS: r = sel_sup2;
            `GPC_SUP3_OFS: r = sel_sup3;
            `GPC_SUP4_OFS: r = sel_sup4;
            `GPC_CSEL_OFS: r = sel_csel;
            default:       r = sel_none;
        endcase
        return r;
    endfunction

    // implemented bits of each register
    function automatic logic [15:0] reg_mask(input gpc_reg_t r);
        logic [15:0] m;
        m = 16'h0000;
        unique case (r)
            sel_none: m = 16'h0000;
            sel_mode: m = `GPC_MODE_MASK;
            sel_sup0: m = `GPC_SUP0_MASK;
            sel_sup1: m = `GPC_SUP8_MASK;
            sel_sup2: m = `GPC_SUP2_MASK;
            sel_sup3: m = `GPC_SUP8_MASK;
            sel_sup4: m = `GPC_SUP8_MASK;
            sel_csel: m = `GPC_CSEL_MASK;
        endcase
        return m;
    endfunction

    // reset release, asserted at once and released after two edges
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // register file
    gpc_reg_t    wr_sel;
    gpc_reg_t    rd_sel;
    logic [15:0] mode_q;
    logic [15:0] mode_d;
    logic [15:0] sup_q [0:4];
    logic [15:0] sup_d [0:4];
    logic [15:0] csel_q;
    logic [15:0] csel_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    assign wr_sel = reg_decode(reg_addr);
    assign rd_sel = reg_decode(reg_addr);

    always_comb begin
        mode_d = mode_q;
        sup_d  = sup_q;
        csel_d = csel_q;
        if (reg_wr) begin
            unique case (wr_sel)
                sel_none: mode_d = mode_q;
                sel_mode: mode_d = reg_wdata & reg_mask(sel_mode);
                sel_sup0: sup_d[0] = reg_wdata & reg_mask(sel_sup0);
                sel_sup1: sup_d[1] = reg_wdata & reg_mask(sel_sup1);
                sel_sup2: sup_d[2] = reg_wdata & reg_mask(sel_sup2);
                sel_sup3: sup_d[3] = reg_wdata & reg_mask(sel_sup3);
                sel_sup4: sup_d[4] = reg_wdata & reg_mask(sel_sup4);
                sel_csel: csel_d = reg_wdata & reg_mask(sel_csel);
            endcase
        end
    end

    // supply selects reset to the high rail
    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= `GPC_MODE_RST;
            for (int i = 0; i < 5; i++) begin
                sup_q[i] <= `GPC_SUP_RST;
            end
            csel_q <= `GPC_CSEL_RST;
        end else begin
            mode_q <= mode_d;
            sup_q  <= sup_d;
            csel_q <= csel_d;
        end
    end

    // read data stand only in the cycle after the strobe
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            unique case (rd_sel)
                sel_none: rdata_d = 16'h0000;
                sel_mode: rdata_d = mode_q;
                sel_sup0: rdata_d = sup_q[0];
                sel_sup1: rdata_d = sup_q[1];
                sel_sup2: rdata_d = sup_q[2];
                sel_sup3: rdata_d = sup_q[3];
                sel_sup4: rdata_d = sup_q[4];
                sel_csel: rdata_d = csel_q;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // field outputs
    gpc_dir_pull_t dir;
    logic [5:0]    func;
    logic          open_drain;

    assign func       = mode_q[`GPC_FUNC_HI:`GPC_FUNC_LO];
    assign dir        = gpc_dir_pull_t'(mode_q[`GPC_DIR_HI:`GPC_DIR_LO]);
    assign open_drain = mode_q[`GPC_DRIVE_BIT];

    assign pin_function_sel     = func;
    assign drive_type_sel       = open_drain;
    assign direction_pull_sel   = mode_q[`GPC_DIR_HI:`GPC_DIR_LO];
    assign pin_clock_source_sel = csel_q[`GPC_CSEL_HI:0];

    // port 0 has pins 6 and 7 only
    assign port0_rail_sel = sup_q[0][`GPC_SUP0_HI:`GPC_SUP0_LO];
    assign port1_rail_sel = sup_q[1][`GPC_SUP_HI:0];
    assign port3_rail_sel = sup_q[3][`GPC_SUP_HI:0];
    assign port4_rail_sel = sup_q[4][`GPC_SUP_HI:0];
    assign port2_rail_sel = sup_q[2][`GPC_SUP2_HI:0];

    // clock routing
    logic routed_clk;

    gpc_clk_route u_clk_route (
        .mclk                  (mclk),
        .rst_n                 (rst_n_q),
        .low_freq_crystal_osc  (low_freq_crystal_osc),
        .low_freq_rc_osc       (low_freq_rc_osc),
        .trimmed_rc_osc        (trimmed_rc_osc),
        .high_freq_crystal_osc (high_freq_crystal_osc),
        .high_freq_rc_osc      (high_freq_rc_osc),
        .divided_system_clock  (divided_system_clock),
        .sel                   (gpc_clk_src_t'(csel_q[`GPC_CSEL_HI:0])),
        .clk_out               (routed_clk)
    );

    // pad control
    logic analog;
    logic is_clock_fn;
    logic pin_data;
    logic out_en;
    logic pad_o_q;
    logic pad_o_d;
    logic pad_oe_q;
    logic pad_oe_d;
    logic in_en_q;
    logic in_en_d;
    logic pu_q;
    logic pu_d;
    logic pd_q;
    logic pd_d;
    logic ana_q;
    logic ana_d;

    always_comb begin
        // function code picks the pin source
        analog      = (func == `GPC_FUNC_ADC);
        is_clock_fn = (func == `GPC_CLOCK_OUTPUT_FUNCTION_OUT);
        // clock function takes the routed clock
        pin_data    = is_clock_fn ? routed_clk : func_out_data;
        // converter mode masks the direction field
        out_en      = !analog && (dir == dir_output);
        in_en_d     = !analog && (dir != dir_output);
        pu_d        = !analog && (dir == dir_in_pullup);
        pd_d        = !analog && (dir == dir_in_pulldn);
        ana_d       = analog;
        if (open_drain) begin
            pad_o_d  = 1'b0;
            pad_oe_d = out_en && !pin_data;
        end else begin
            pad_o_d  = out_en && pin_data;
            pad_oe_d = out_en;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pad_o_q  <= 1'b0;
            pad_oe_q <= 1'b0;
            in_en_q  <= 1'b1;
            pu_q     <= 1'b0;
            pd_q     <= 1'b1;
            ana_q    <= 1'b0;
        end else begin
            pad_o_q  <= pad_o_d;
            pad_oe_q <= pad_oe_d;
            in_en_q  <= in_en_d;
            pu_q     <= pu_d;
            pd_q     <= pd_d;
            ana_q    <= ana_d;
        end
    end

    assign pad_o            = pad_o_q;
    assign pad_oe           = pad_oe_q;
    assign pad_input_en     = in_en_q;
    assign pad_pull_up_en   = pu_q;
    assign pad_pull_down_en = pd_q;
    assign pad_analog_en    = ana_q;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_q);

    open_drain_low_a: assert property (
        $past(open_drain) && pad_oe_q |-> !pad_o_q)
        else $error("open-drain pad drove high");

    output_only_11_a: assert property (
        pad_oe_q |-> $past(dir == dir_output) && !$past(analog))
        else $error("pad driven without output code");

    pull_decode_a: assert property (
        !$past(analog) |-> pu_q == ($past(dir) == dir_in_pullup)
                           && pd_q == ($past(dir) == dir_in_pulldn))
        else $error("pull enables disagree with code");

    reset_pulldown_a: assert property (
        $rose(rst_n_q) |-> dir == dir_in_pulldn && !open_drain && func == 6'h00)
        else $error("mode field reset value wrong");

    adc_ignores_dir_a: assert property (
        $past(analog) |-> ana_q && !pad_oe_q && !pu_q && !pd_q && !in_en_q)
        else $error("converter mode used the direction field");

    port0_rail_a: assert property (
        reg_wr && wr_sel == sel_sup0 |=> port0_rail_sel == $past(reg_wdata[7:6]))
        else $error("port 0 rail select not written");

    port1_rail_a: assert property (
        reg_wr && wr_sel == sel_sup1 |=> port1_rail_sel == $past(reg_wdata[7:0]))
        else $error("port 1 rail select not written");

    port2_reserved_a: assert property (
        reg_rd && rd_sel == sel_sup2 |=> reg_rdata[15:5] == 11'h000)
        else $error("port 2 reserved bits read nonzero");

    rail_reset_a: assert property (
        $rose(rst_n_q) |-> port1_rail_sel == 8'h00 && port4_rail_sel == 8'h00
                           && port0_rail_sel == 2'h0 && port2_rail_sel == 5'h00)
        else $error("rail selects not reset to high rail");

    clock_route_a: assert property (
        $past(is_clock_fn && out_en && !open_drain) |-> pad_o_q == $past(routed_clk))
        else $error("pin not carrying the routed clock");

    read_back_a: assert property (
        reg_wr && wr_sel == sel_mode ##1 reg_rd && rd_sel == sel_mode
        |=> reg_rdata == ($past(reg_wdata, 2) & `GPC_MODE_MASK))
        else $error("mode register read back wrong");

    read_idle_zero_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside the answer cycle");

    clock_fn_cover_c: cover property (is_clock_fn && out_en && routed_clk);
    open_drain_cover_c: cover property (open_drain && pad_oe_q);
    adc_cover_c: cover property (analog && dir == dir_output);
    reserved_src_cover_c: cover property (is_clock_fn && csel_q[2:1] == 2'b11);

endmodule

`default_nettype wire

// ---- verilog/gpc_pkg.sv ----
// types shared by the pad configuration block
package gpc_pkg;

    typedef enum logic [1:0] {
        dir_in_plain  = 2'b00,
        dir_in_pullup = 2'b01,
        dir_in_pulldn = 2'b10,
        dir_output    = 2'b11
    } gpc_dir_pull_t;

    typedef enum logic [2:0] {
        src_low_freq_crystal  = 3'b000,
        src_low_freq_rc       = 3'b001,
        src_trimmed_rc        = 3'b010,
        src_high_freq_crystal = 3'b011,
        src_high_freq_rc      = 3'b100,
        src_divided_sys       = 3'b101,
        src_reserved6         = 3'b110,
        src_reserved7         = 3'b111
    } gpc_clk_src_t;

    typedef enum logic [2:0] {
        sel_none = 3'b000,
        sel_mode = 3'b001,
        sel_sup0 = 3'b010,
        sel_sup1 = 3'b011,
        sel_sup2 = 3'b100,
        sel_sup3 = 3'b101,
        sel_sup4 = 3'b110,
        sel_csel = 3'b111
    } gpc_reg_t;

endpackage

// ---- verilog/gpc_regs.svh ----
// register offsets, field positions, reset values and codes of the pad configuration block
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_ADDR_W          32
`define GPC_DATA_W          16

`define GPC_MODE_OFS        32'h5000_306c
`define GPC_SUP0_OFS        32'h5000_30c0
`define GPC_SUP1_OFS        32'h5000_30c2
`define GPC_SUP2_OFS        32'h5000_30c4
`define GPC_SUP3_OFS        32'h5000_30c6
`define GPC_SUP4_OFS        32'h5000_30c8
`define GPC_CSEL_OFS        32'h5000_30d0

`define GPC_DRIVE_BIT       10
`define GPC_DIR_HI          9
`define GPC_DIR_LO          8
`define GPC_FUNC_HI         5
`define GPC_FUNC_LO         0
`define GPC_SUP0_HI         7
`define GPC_SUP0_LO         6
`define GPC_SUP2_HI         4
`define GPC_SUP_HI          7
`define GPC_CSEL_HI         2

`define GPC_MODE_MASK       16'h073f
`define GPC_SUP0_MASK       16'h00c0
`define GPC_SUP8_MASK       16'h00ff
`define GPC_SUP2_MASK       16'h001f
`define GPC_CSEL_MASK       16'h0007

`define GPC_MODE_RST        16'h0200
`define GPC_SUP_RST         16'h0000
`define GPC_CSEL_RST        16'h0000
`define GPC_DIR_RST         2'h2

`define GPC_CLOCK_OUTPUT_FUNCTION_OUT  6'h30
`define GPC_FUNC_ADC        6'h0f

`endif
